// ### sps_present_state.v
// Socket present state register with its event flags, force path and Wishbone slave
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "sps_defines.vh"

module sps_present_state (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire detect_line_one_n,
  input wire detect_line_two_n,
  input wire ready_irq_line,
  input wire status_change_line,
  input wire identify_busy,
  input wire identify_done,
  input wire [3:0] identify_volts,
  input wire identify_cardbus,
  input wire identify_sixteen,
  input wire identify_unknown,
  input wire socket_powered,
  input wire invalid_supply_hit,
  input wire removal_loss_hit,
  input wire high_volt_disable,
  output wire voltage_sense_retest,
  output wire power_control_enable,
  output wire [3:0] event_flags
);

  // Bus slave state
  reg [31:0] dat_ff;
  reg ack_ff;

  // Present state fields
  reg [2:0] caps_ff;
  reg zv_ff;
  reg [3:0] volts_ff;
  reg badvcc_ff;
  reg lost_ff;
  reg notcard_ff;
  reg ready_ff;
  reg cb_ff;
  reg sixteen_ff;
  reg pwr_ff;
  reg det2_ff;
  reg det1_ff;
  reg sts_ff;

  // Event flags and side outputs
  reg [3:0] event_ff;
  reg retest_ff;
  reg pwr_ctl_ff;

  // Next values
  reg [2:0] nxt_caps;
  reg nxt_zv;
  reg [3:0] nxt_volts;
  reg nxt_badvcc;
  reg nxt_lost;
  reg nxt_notcard;
  reg nxt_cb;
  reg nxt_sixteen;
  reg nxt_det2;
  reg nxt_det1;
  reg [3:0] nxt_event;
  reg nxt_pwr_ctl;
  reg [3:0] ev_set;
  reg [3:0] ev_clr;
  // Level mirror next values
  reg nxt_ready;
  reg nxt_pwr;
  reg nxt_sts;
  reg nxt_retest;
  // Read answer next values
  reg nxt_ack;
  reg [31:0] nxt_dat;
  reg [31:0] event_word;
  reg [31:0] state_word;

  wire [3:0] sync_lines;
  wire bus_req;
  wire wr_take;
  wire wr_event;
  wire wr_force;
  wire [31:0] wr_bits;
  wire [31:0] wr_mask;

  // Byte lane enables widened to a bit mask
  function [31:0] sps_lane_mask;
    input [3:0] sel;
    begin
      sps_lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // Offset compare, shared by read mux and write strobes
  function sps_hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      sps_hit = (adr[`SPS_ADR_W-1:2] == ofs[`SPS_ADR_W-1:2]);
    end
  endfunction

  // Change detect: both edges, or the rising edge only when asked
  function sps_change;
    input now_lvl;
    input was_lvl;
    input rise_only;
    begin
      if (rise_only)
        sps_change = now_lvl & ~was_lvl;
      else
        sps_change = now_lvl ^ was_lvl;
    end
  endfunction

  // Socket lines cross into the clock domain first
  sps_line_sync #(
    .WIDTH(`SPS_SYNC_W),
    .RST_VAL(`SPS_SYNC_RST)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .line_in({status_change_line, ready_irq_line, detect_line_two_n, detect_line_one_n}),
    .line_out(sync_lines)
  );

  // Single-cycle handshake, one ack per request
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_take = bus_req & wb_we_i;
  assign wr_event = wr_take & sps_hit(wb_adr_i, `SPS_OFS_EVENT);
  assign wr_force = wr_take & sps_hit(wb_adr_i, `SPS_OFS_FORCE);
  assign wr_mask = sps_lane_mask(wb_sel_i);
  assign wr_bits = wb_dat_i & wr_mask;

  // Register image built field by field, so a moved field cannot shift its neighbours
  always @*
  begin
    state_word = `SPS_RST_WORD;
    state_word[`SPS_B_FUT_Y:`SPS_B_LOW_V] = caps_ff;
    state_word[`SPS_B_HIGH_V] = ~high_volt_disable;
    state_word[`SPS_B_ZV] = zv_ff;
    state_word[`SPS_B_CARD_HI:`SPS_B_CARD_LO] = volts_ff;
    state_word[`SPS_B_BADVCC] = badvcc_ff;
    state_word[`SPS_B_LOST] = lost_ff;
    state_word[`SPS_B_NOTCARD] = notcard_ff;
    state_word[`SPS_B_READY] = ready_ff;
    state_word[`SPS_B_CB] = cb_ff;
    state_word[`SPS_B_16] = sixteen_ff;
    state_word[`SPS_B_PWR] = pwr_ff;
    state_word[`SPS_B_DET2] = det2_ff;
    state_word[`SPS_B_DET1] = det1_ff;
    state_word[`SPS_B_STS] = sts_ff;
  end

  // Card data, flags and force effects
  always @*
  begin
    nxt_caps = caps_ff;
    nxt_zv = zv_ff;
    nxt_volts = volts_ff;
    nxt_badvcc = badvcc_ff | invalid_supply_hit;
    nxt_lost = lost_ff | removal_loss_hit;
    nxt_notcard = notcard_ff;
    nxt_cb = cb_ff;
    nxt_sixteen = sixteen_ff;
    nxt_pwr_ctl = pwr_ctl_ff;
    // Insertion results overwrite the card fields; force writes can only set bits in them
    if (identify_done)
    begin
      nxt_volts = identify_volts;
      nxt_cb = identify_cardbus;
      nxt_sixteen = identify_sixteen;
      nxt_badvcc = invalid_supply_hit;
      nxt_lost = removal_loss_hit;
      // Flag stays until a recognisable card is found
      if (identify_unknown)
        nxt_notcard = 1'b1;
      else
        nxt_notcard = 1'b0;
    end
    // Force writes land after insertion results so forced bits are ORed onto them in a tie
    if (wr_force)
    begin
      if (wb_sel_i[3])
      begin
        nxt_caps = wb_dat_i[`SPS_B_FUT_Y:`SPS_B_LOW_V];
        nxt_zv = wb_dat_i[`SPS_B_ZV];
      end
      nxt_volts = nxt_volts | wr_bits[`SPS_B_CARD_HI:`SPS_B_CARD_LO];
      // A forced card voltage takes power control away from hardware unless the same write also sets the retest bit
      if (|wr_bits[`SPS_B_CARD_HI:`SPS_B_CARD_LO])
        nxt_pwr_ctl = 1'b0;
      nxt_badvcc = nxt_badvcc | wr_bits[`SPS_B_BADVCC];
      nxt_lost = nxt_lost | wr_bits[`SPS_B_LOST];
      nxt_notcard = nxt_notcard | wr_bits[`SPS_B_NOTCARD];
      nxt_cb = nxt_cb | wr_bits[`SPS_B_CB];
      nxt_sixteen = nxt_sixteen | wr_bits[`SPS_B_16];
      if (wr_bits[`SPS_B_RETEST])
        nxt_pwr_ctl = 1'b1;
    end
  end

  // Detect lines freeze while the card is being identified
  always @*
  begin
    nxt_det1 = det1_ff;
    nxt_det2 = det2_ff;
    if (!identify_busy)
    begin
      nxt_det1 = sync_lines[`SPS_LN_DET1];
      nxt_det2 = sync_lines[`SPS_LN_DET2];
    end
  end

  // Event flags: change detect or force sets, write-one clears, set wins
  always @*
  begin
    ev_set = {`SPS_EV_W{1'b0}};
    ev_set[`SPS_EV_PWR] = sps_change(nxt_pwr, pwr_ff, 1'b0);
    ev_set[`SPS_EV_DET2] = sps_change(nxt_det2, det2_ff, 1'b0);
    ev_set[`SPS_EV_DET1] = sps_change(nxt_det1, det1_ff, 1'b0);
    // CardBus cards only flag the rising edge of status change
    ev_set[`SPS_EV_STS] = sps_change(nxt_sts, sts_ff, cb_ff);
    if (wr_force)
      ev_set = ev_set | wr_bits[`SPS_EV_W-1:0];
    ev_clr = {`SPS_EV_W{1'b0}};
    if (wr_event)
      ev_clr = wr_bits[`SPS_EV_W-1:0];
    nxt_event = (event_ff & ~ev_clr) | ev_set;
  end

  // Level mirrors follow their sources every cycle; power is taken as already synchronous
  always @*
  begin
    nxt_ready = sync_lines[`SPS_LN_READY];
    nxt_pwr = socket_powered;
    nxt_sts = sync_lines[`SPS_LN_STS];
    nxt_retest = wr_force & wr_bits[`SPS_B_RETEST];
  end

  // State registers
  always @(posedge clk)
  begin
    if (rst)
    begin
      caps_ff <= `SPS_RST_CAPS;
      zv_ff <= 1'b0;
      volts_ff <= `SPS_RST_VOLTS;
      badvcc_ff <= 1'b0;
      lost_ff <= 1'b0;
      notcard_ff <= 1'b0;
      ready_ff <= 1'b0;
      cb_ff <= 1'b0;
      sixteen_ff <= 1'b0;
      pwr_ff <= 1'b0;
      det2_ff <= `SPS_RST_DETECT;
      det1_ff <= `SPS_RST_DETECT;
      sts_ff <= 1'b0;
      event_ff <= `SPS_RST_EVENT;
      retest_ff <= 1'b0;
      pwr_ctl_ff <= 1'b1;
    end
    else
    begin
      caps_ff <= nxt_caps;
      zv_ff <= nxt_zv;
      volts_ff <= nxt_volts;
      badvcc_ff <= nxt_badvcc;
      lost_ff <= nxt_lost;
      notcard_ff <= nxt_notcard;
      ready_ff <= nxt_ready;
      cb_ff <= nxt_cb;
      sixteen_ff <= nxt_sixteen;
      pwr_ff <= nxt_pwr;
      det2_ff <= nxt_det2;
      det1_ff <= nxt_det1;
      sts_ff <= nxt_sts;
      event_ff <= nxt_event;
      retest_ff <= nxt_retest;
      pwr_ctl_ff <= nxt_pwr_ctl;
    end
  end

  // Read mux; data is zero outside a read answer so stale words never leak
  always @*
  begin
    nxt_ack = bus_req;
    nxt_dat = `SPS_RST_WORD;
    event_word = `SPS_RST_WORD;
    event_word[`SPS_EV_W-1:0] = event_ff;
    if (bus_req && !wb_we_i)
    begin
      if (sps_hit(wb_adr_i, `SPS_OFS_STATE))
        nxt_dat = state_word;
      else if (sps_hit(wb_adr_i, `SPS_OFS_EVENT))
        nxt_dat = event_word;
    end
  end

  // Bus answer; writes to the present state offset change nothing
  always @(posedge clk)
  begin
    if (rst)
    begin
      ack_ff <= 1'b0;
      dat_ff <= `SPS_RST_WORD;
    end
    else
    begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
  assign voltage_sense_retest = retest_ff;
  assign power_control_enable = pwr_ctl_ff;
  assign event_flags = event_ff;

endmodule // sps_present_state

// ### sps_defines.vh
// Address map, field positions and reset values of the socket present state block
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

// Register byte offsets inside the socket window
`define SPS_OFS_EVENT 8'h00
`define SPS_OFS_MASK 8'h04
`define SPS_OFS_STATE 8'h08
`define SPS_OFS_FORCE 8'h0c
`define SPS_ADR_W 8

// Present state field positions
`define SPS_B_FUT_Y 31
`define SPS_B_FUT_X 30
`define SPS_B_LOW_V 29
`define SPS_B_HIGH_V 28
`define SPS_B_ZV 27
`define SPS_B_CARD_HI 13
`define SPS_B_CARD_LO 10
`define SPS_B_BADVCC 9
`define SPS_B_LOST 8
`define SPS_B_NOTCARD 7
`define SPS_B_READY 6
`define SPS_B_CB 5
`define SPS_B_16 4
`define SPS_B_PWR 3
`define SPS_B_DET2 2
`define SPS_B_DET1 1
`define SPS_B_STS 0

// Force register fields not shared with present state
`define SPS_B_RETEST 14

// Event register fields
`define SPS_EV_PWR 3
`define SPS_EV_DET2 2
`define SPS_EV_DET1 1
`define SPS_EV_STS 0
`define SPS_EV_W 4

// Synchroniser lane order: {status, ready, detect two, detect one}
`define SPS_SYNC_W 4
`define SPS_SYNC_RST 4'h3
`define SPS_LN_DET1 0
`define SPS_LN_DET2 1
`define SPS_LN_READY 2
`define SPS_LN_STS 3

// Reset values
`define SPS_RST_CAPS 3'h1
`define SPS_RST_VOLTS 4'h0
`define SPS_RST_EVENT 4'h0
`define SPS_RST_WORD 32'h00000000
`define SPS_RST_DETECT 1'b1

`endif

// ### sps_line_sync.v
// Two-flop synchroniser for the socket sense lines
`timescale 1ns/1ps
`include "sps_defines.vh"

module sps_line_sync #(
  parameter WIDTH = `SPS_SYNC_W,
  parameter [WIDTH-1:0] RST_VAL = `SPS_SYNC_RST
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] line_in,
  output wire [WIDTH-1:0] line_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= line_in;
      sync_ff <= meta_ff;
    end
  end

  assign line_out = sync_ff;

endmodule // sps_line_sync

// ### sps_checker.sv
// Port assertions for the socket present state block
`timescale 1ns/1ps
module sps_checker (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire identify_busy,
  input wire socket_powered,
  input wire high_volt_disable,
  input wire voltage_sense_retest,
  input wire power_control_enable,
  input wire [3:0] event_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Answer to a read of the state word, and a force write asking for a retest
  wire rd_st = wb_ack_o && !wb_we_i && wb_adr_i == 8'h08;
  wire frc = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h0c && wb_dat_i[14];
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_next_a: assert property (take_s |=> wb_ack_o)
    else $error("ack late");
  reserved_zero_a: assert property (rd_st |-> wb_dat_o[26:14] == 13'h0)
    else $error("reserved bits set");
  future_caps_a: assert property (rd_st |-> wb_dat_o[31:30] == 2'h0)
    else $error("future caps set");
  // Held over three samples, so read timing cannot matter
  high_volt_a: assert property (rd_st && $stable(high_volt_disable) &&
    $past(high_volt_disable, 2) == high_volt_disable |-> wb_dat_o[28] == !high_volt_disable)
    else $error("high volt bit wrong");
  power_event_a: assert property ($changed(socket_powered) |=> event_flags[3])
    else $error("power event missing");
  retest_cause_a: assert property ($rose(voltage_sense_retest) |-> $past(frc))
    else $error("retest without write");
  retest_power_a: assert property (voltage_sense_retest |-> ##[0:1] power_control_enable)
    else $error("power control off");
  frozen_detect_a: assert property (identify_busy && $past(identify_busy) &&
    !$past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h0c) |->
    !$rose(event_flags[1]) && !$rose(event_flags[2]))
    else $error("detect event while busy");
endmodule // sps_checker

// ### sps_card_model.sv
// Card in the socket: detect, ready and status lines
`timescale 1ns/1ps
module sps_card_model (
  input wire clk,
  input wire ins,
  output logic cd1_n = 1'b1,
  output logic cd2_n = 1'b1,
  output logic rdy = 1'b0,
  output logic sts = 1'b0
);
  // Contacts close one after the other; pulled levels once removed
  always @(posedge clk)
  begin
    cd1_n <= !ins;
    cd2_n <= cd1_n;
    rdy <= ins;
    sts <= ins;
  end
endmodule // sps_card_model

// ### tb_top.sv
// Self-checking bench for the socket present state register
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, volts = 4'h0;
  logic [31:0] wd = 32'h0;
  logic ins = 1'b0, busy = 1'b0, done = 1'b0, cb = 1'b0, unk = 1'b0;
  logic pwr = 1'b0, bad = 1'b0, lost = 1'b0, hvd = 1'b0;
  logic [31:0] rd;
  logic ack, d1, d2, rdy, sts, retest, pce;
  logic [3:0] ev;
  int failures = 0, check_count = 0, cyc_n = 0;
  int retest_n = 0;
  always #20 clk = ~clk;
  // Counts retest pulses so a stuck or doubled pulse shows up
  always @(posedge clk)
    if (retest === 1'b1)
      retest_n <= retest_n + 1;
  sps_card_model card (.clk(clk), .ins(ins), .cd1_n(d1), .cd2_n(d2), .rdy(rdy), .sts(sts));
  sps_present_state uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .detect_line_one_n(d1), .detect_line_two_n(d2), .ready_irq_line(rdy),
    .status_change_line(sts), .identify_busy(busy), .identify_done(done),
    .identify_volts(volts), .identify_cardbus(cb), .identify_sixteen(!cb),
    .identify_unknown(unk), .socket_powered(pwr), .invalid_supply_hit(bad),
    .removal_loss_hit(lost), .high_volt_disable(hvd), .voltage_sense_retest(retest),
    .power_control_enable(pce), .event_flags(ev));
  task automatic report_and_stop();
  begin
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // Hang guard: the sequence needs about a hundred cycles
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000)
    begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
  begin
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // One classic cycle; request held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d, output logic [31:0] q);
  begin
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wd <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
  begin
    xfer(1'b1, a, s, d, q);
  end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
  begin
    xfer(1'b0, a, 4'hf, 32'h0, q);
    chk("read word", q, e);
  end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Main sequence
  initial
  begin
    tick(16);
    rst <= 1'b0;
    tick(6);
    rdc(8'h08, 32'h3000_0006);
    wr(8'h08, 4'hf, 32'hffff_ffff);
    rdc(8'h08, 32'h3000_0006);
    rdc(8'h10, 32'h0000_0000);
    hvd <= 1'b1;
    tick(2);
    rdc(8'h08, 32'h2000_0006);
    hvd <= 1'b0;
    ins <= 1'b1;
    tick(6);
    rdc(8'h08, 32'h3000_0041);
    chk("events", {28'h0, ev}, 32'h7);
    wr(8'h00, 4'hf, 32'hf);
    chk("events", {28'h0, ev}, 32'h0);
    volts <= 4'h3;
    cb <= 1'b1;
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    volts <= 4'hc;
    tick(2);
    rdc(8'h08, 32'h3000_0c61);
    pwr <= 1'b1;
    bad <= 1'b1;
    lost <= 1'b1;
    tick(1);
    bad <= 1'b0;
    lost <= 1'b0;
    tick(2);
    chk("events", {28'h0, ev}, 32'h8);
    rdc(8'h08, 32'h3000_0f69);
    unk <= 1'b1;
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    tick(1);
    rdc(8'h08, 32'h3000_30e9);
    busy <= 1'b1;
    ins <= 1'b0;
    tick(6);
    rdc(8'h08, 32'h3000_30a8);
    busy <= 1'b0;
    tick(3);
    rdc(8'h08, 32'h3000_30ae);
    rdc(8'h00, 32'h0000_000e);
    wr(8'h0c, 4'h2, 32'h0000_0400);
    chk("power control", {31'h0, pce}, 32'h0);
    rdc(8'h08, 32'h3000_34ae);
    wr(8'h0c, 4'ha, 32'h2800_4000);
    chk("power control", {31'h0, pce}, 32'h1);
    rdc(8'h08, 32'h3800_34ae);
    chk("retest pulses", retest_n, 32'h1);
    wr(8'h00, 4'hf, 32'hf);
    chk("events", {28'h0, ev}, 32'h0);
    wr(8'h0c, 4'h1, 32'h0000_0001);
    chk("events", {28'h0, ev}, 32'h1);
    rdc(8'h08, 32'h3800_34ae);
    report_and_stop();
  end
endmodule // tb_top
bind sps_present_state sps_checker chk_i (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .identify_busy(identify_busy),
  .socket_powered(socket_powered), .high_volt_disable(high_volt_disable),
  .voltage_sense_retest(voltage_sense_retest), .power_control_enable(power_control_enable),
  .event_flags(event_flags));
